// *** logic/tilt_node.sv ***
// Purpose: Node end: address claim, control command decode, periodic broadcast.
// Assumes: Serial value and data payload come from same-clock logic.
// Notes: Non-volatile store is a write strobe with the new address; the
//        stored address is loaded at reset release through NV_SA_VALID.

// Function
// - Claim once after 500 ms, then on request
// - Claim id: priority 6, EE, FF, own SA
// - Serial bits 0-20 in bytes 0-2
// - Maker code bits in byte 2 and 3
// - Byte 4 is zero
// - Byte 5 is function 136
// - Byte 6 is zero
// - Byte 7 holds industry group 3
// - Byte 7 bit 7 cleared, not arbitrary
// - Request EA to own SA gets claim
// - Request bytes: requestor, EA, target SA
// - Commands only on 0x10FF54 identifier
// - Byte 0 is the command code
// - Code 00 sends serial-number frame
// - Code 01 stores new SA in NVM
// - Code 02 silences broadcasts and answers
// - Code 03 resumes broadcasts and answers
// - Master learns serials, assigns distinct addresses
// - SA C0 uninitialised, range 80 to F7
// - Data frame PS 53 every 10 ms
module tilt_node #(
    parameter logic [10:0] MAKER_CODE = 11'h123, // Value is arbitrary.
    parameter int STARTUP_CNT = claim_pkg::STARTUP_CYCLES,
    parameter int PERIOD_CNT = claim_pkg::PERIOD_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    claim_if.node LINK,
    input wire logic [20:0] SERIAL_NUM,
    input wire logic [63:0] SERIAL_FRAME,
    input wire logic [63:0] DATA_FRAME,
    input wire logic [7:0] NV_SA,
    input wire logic NV_SA_VALID,
    output logic NV_WRITE,
    output logic [7:0] NV_WDATA,
    output logic [7:0] SOURCE_ADDR,
    output logic SILENT
);
    import claim_pkg::*;
    // ============================================================
    // Types and state
    typedef enum logic [2:0] {
        ST_BOOT = 3'b001,
        ST_RUN = 3'b010,
        ST_QUIET = 3'b100
    } node_e;

    node_e state_reg;
    logic [31:0] boot_cnt_reg;
    logic [31:0] tick_cnt_reg;
    logic claim_pend_reg;
    logic serial_pend_reg;
    logic data_pend_reg;
    logic [7:0] sa_reg;
    logic sa_loaded_reg;
    logic dn_ready_reg;

    logic tx_free;
    logic tx_load;
    logic [28:0] tx_id;
    logic [63:0] tx_data;
    logic [63:0] claim_data;

    logic rx_take;
    logic is_request;
    logic is_control;
    logic [7:0] cmd;

    // ============================================================
    // Receive decode
    assign rx_take = LINK.dn_valid && dn_ready_reg;
    assign is_request = LINK.dn_id[28:26] == PRIO_CLAIM && LINK.dn_id[23:16] == PF_REQUEST
        && LINK.dn_id[15:8] == sa_reg && LINK.dn_data[15:8] == PF_REQUEST
        && LINK.dn_data[23:16] == sa_reg;
    assign is_control = LINK.dn_id[28:8] == {PRIO_CTRL, 2'h0, PF_PROP_B, PS_CONTROL};
    assign cmd = LINK.dn_data[7:0];

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dn_ready_reg <= 1'b0;
        end else begin
            dn_ready_reg <= 1'b1;
        end
    end

    // ============================================================
    // Mode control
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= ST_BOOT;
            boot_cnt_reg <= 32'h0;
        end else begin
            case (state_reg)
                ST_BOOT: begin
                    if (boot_cnt_reg == 32'(STARTUP_CNT - 1)) begin
                        state_reg <= ST_RUN;
                    end else begin
                        boot_cnt_reg <= boot_cnt_reg + 32'h1;
                    end
                end
                ST_RUN: begin
                    if (rx_take && is_control && cmd == CMD_WAIT) begin
                        state_reg <= ST_QUIET;
                    end
                end
                ST_QUIET: begin
                    if (rx_take && is_control && cmd == CMD_RESUME) begin
                        state_reg <= ST_RUN;
                    end
                end
                default: state_reg <= ST_BOOT;
            endcase
        end
    end

    // ============================================================
    // Source address and non-volatile store
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            sa_reg <= SA_UNINIT;
            sa_loaded_reg <= 1'b0;
            NV_WRITE <= 1'b0;
            NV_WDATA <= 8'h0;
        end else begin
            NV_WRITE <= 1'b0;
            if (!sa_loaded_reg) begin
                sa_loaded_reg <= 1'b1;
                if (NV_SA_VALID && NV_SA >= SA_MIN && NV_SA <= SA_MAX) begin
                    sa_reg <= NV_SA;
                end
            end else if (rx_take && is_control && cmd == CMD_SET_SA && state_reg != ST_QUIET
                         && LINK.dn_data[15:8] >= SA_MIN && LINK.dn_data[15:8] <= SA_MAX) begin
                sa_reg <= LINK.dn_data[15:8];
                NV_WRITE <= 1'b1;
                NV_WDATA <= LINK.dn_data[15:8];
            end
        end
    end

    // ============================================================
    // Pending transmissions; a new cause wins over the clear.
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            claim_pend_reg <= 1'b0;
            serial_pend_reg <= 1'b0;
            data_pend_reg <= 1'b0;
            tick_cnt_reg <= 32'h0;
        end else begin
            if (state_reg == ST_BOOT && boot_cnt_reg == 32'(STARTUP_CNT - 1)) begin
                claim_pend_reg <= 1'b1;
            end else if (rx_take && is_request && state_reg == ST_RUN) begin
                claim_pend_reg <= 1'b1;
            end else if (tx_load && tx_id[23:16] == PF_CLAIM) begin
                claim_pend_reg <= 1'b0;
            end
            if (rx_take && is_control && cmd == CMD_SERIAL && state_reg == ST_RUN) begin
                serial_pend_reg <= 1'b1;
            end else if (tx_load && tx_id[15:8] == PS_SERIAL) begin
                serial_pend_reg <= 1'b0;
            end
            if (state_reg == ST_RUN && tick_cnt_reg == 32'(PERIOD_CNT - 1)) begin
                tick_cnt_reg <= 32'h0;
                data_pend_reg <= 1'b1;
            end else begin
                if (state_reg == ST_RUN) begin
                    tick_cnt_reg <= tick_cnt_reg + 32'h1;
                end
                if (state_reg == ST_QUIET) begin
                    data_pend_reg <= 1'b0;
                end else if (tx_load && tx_id[15:8] == PS_DATA) begin
                    data_pend_reg <= 1'b0;
                end
            end
        end
    end

    // ============================================================
    // Frame selection, claim first
    assign claim_data = {NAME_BYTE7, NAME_VSYS, NAME_FUNCTION, NAME_INSTANCE,
                         MAKER_CODE[10:3], MAKER_CODE[2:0], SERIAL_NUM};

    always_comb begin
        tx_load = 1'b0;
        tx_id = 29'h0;
        tx_data = 64'h0;
        if (tx_free && state_reg != ST_QUIET) begin
            if (claim_pend_reg) begin
                tx_load = 1'b1;
                tx_id = make_id(PRIO_CLAIM, PF_CLAIM, PS_GLOBAL, sa_reg);
                tx_data = claim_data;
            end else if (serial_pend_reg) begin
                tx_load = 1'b1;
                tx_id = make_id(PRIO_CTRL, PF_PROP_B, PS_SERIAL, sa_reg);
                tx_data = SERIAL_FRAME;
            end else if (data_pend_reg) begin
                tx_load = 1'b1;
                tx_id = make_id(PRIO_CTRL, PF_PROP_B, PS_DATA, sa_reg);
                tx_data = DATA_FRAME;
            end
        end
    end

    frame_tx_hold u_hold (
        .CORE_CLK(CORE_CLK),
        .RST(RST),
        .load(tx_load),
        .load_id(tx_id),
        .load_data(tx_data),
        .free(tx_free),
        .valid_reg(LINK.up_valid),
        .id_reg(LINK.up_id),
        .data_reg(LINK.up_data),
        .ready(LINK.up_ready)
    );

    assign LINK.dn_ready = dn_ready_reg;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            SOURCE_ADDR <= SA_UNINIT;
            SILENT <= 1'b0;
        end else begin
            SOURCE_ADDR <= sa_reg;
            SILENT <= state_reg == ST_QUIET;
        end
    end
endmodule

// *** inc/claim_pkg.sv ***
// Purpose: Shared constants for the network-management link of the tilt node.
// Assumes: 25 MHz core clock; frames carried as 29-bit identifier plus 8 bytes.
// Notes: Identifier layout is priority, two zero bits, PDU format, PDU specific, source.
package claim_pkg;
    // ============================================================
    // Timing
    localparam int CLK_HZ = 25_000_000;
    localparam int STARTUP_MS = 500;
    localparam int STARTUP_CYCLES = CLK_HZ / 1000 * STARTUP_MS;
    localparam int PERIOD_MS = 10;
    localparam int PERIOD_CYCLES = CLK_HZ / 1000 * PERIOD_MS;
    // ============================================================
    // Identifier fields
    localparam logic [2:0] PRIO_CLAIM = 3'h6;
    localparam logic [2:0] PRIO_CTRL = 3'h4;
    localparam logic [7:0] PF_CLAIM = 8'hEE;
    localparam logic [7:0] PF_REQUEST = 8'hEA;
    localparam logic [7:0] PF_PROP_B = 8'hFF;
    localparam logic [7:0] PS_GLOBAL = 8'hFF;
    localparam logic [7:0] PS_SERIAL = 8'h52;
    localparam logic [7:0] PS_DATA = 8'h53;
    localparam logic [7:0] PS_CONTROL = 8'h54;
    // ============================================================
    // Addresses
    localparam logic [7:0] SA_UNINIT = 8'hC0;
    localparam logic [7:0] SA_MIN = 8'h80;
    localparam logic [7:0] SA_MAX = 8'hF7;
    // ============================================================
    // Command codes
    localparam logic [7:0] CMD_SERIAL = 8'h00;
    localparam logic [7:0] CMD_SET_SA = 8'h01;
    localparam logic [7:0] CMD_WAIT = 8'h02;
    localparam logic [7:0] CMD_RESUME = 8'h03;
    localparam logic [7:0] FILL_UNUSED = 8'hFF;
    // ============================================================
    // Claim payload constants
    localparam logic [7:0] NAME_INSTANCE = 8'h00;
    localparam logic [7:0] NAME_FUNCTION = 8'h88;
    localparam logic [7:0] NAME_VSYS = 8'h00;
    localparam logic [7:0] NAME_BYTE7 = 8'h30;

    function automatic logic [28:0] make_id(logic [2:0] p, logic [7:0] pf, logic [7:0] ps,
                                            logic [7:0] sa);
        make_id = {p, 2'h0, pf, ps, sa};
    endfunction
endpackage

// *** inc/claim_if.sv ***
// Purpose: Frame link between the node's network logic and the bus master logic.
// Assumes: One clock; each frame is held valid until it is taken with ready high.
// Notes: Both directions carry a 29-bit identifier and eight payload bytes.
interface claim_if;
    logic up_valid;
    logic up_ready;
    logic [28:0] up_id;
    logic [63:0] up_data;
    logic dn_valid;
    logic dn_ready;
    logic [28:0] dn_id;
    logic [63:0] dn_data;
    modport node (output up_valid, output up_id, output up_data, input up_ready,
                  input dn_valid, input dn_id, input dn_data, output dn_ready);
    modport master (input up_valid, input up_id, input up_data, output up_ready,
                    output dn_valid, output dn_id, output dn_data, input dn_ready);
endinterface

// *** logic/frame_tx_hold.sv ***
// Purpose: One-frame holding stage that keeps a frame until the link takes it.
// Assumes: Loader only loads when free is high.
// Notes: Valid, id and data outputs are registered; free is combinational.
module frame_tx_hold (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic load,
    input wire logic [28:0] load_id,
    input wire logic [63:0] load_data,
    output logic free,
    output logic valid_reg,
    output logic [28:0] id_reg,
    output logic [63:0] data_reg,
    input wire logic ready
);
    assign free = !valid_reg || ready;

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            valid_reg <= 1'b0;
        end else if (load && free) begin
            valid_reg <= 1'b1;
        end else if (ready) begin
            valid_reg <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            id_reg <= 29'h0;
            data_reg <= 64'h0;
        end else if (load && free) begin
            id_reg <= load_id;
            data_reg <= load_data;
        end
    end
endmodule

// *** logic/bus_master.sv ***
// Purpose: Master end: issues claim requests and control commands, takes node frames.
// Assumes: User gives one command per CMD_VALID pulse while CMD_READY is high.
// Notes: Frame fields beyond the command are built here.

module bus_master (
    input wire logic CORE_CLK,
    input wire logic RST,
    claim_if.master LINK,
    input wire logic [7:0] MY_SA,
    input wire logic CMD_VALID,
    input wire logic CMD_IS_REQUEST,
    input wire logic [7:0] CMD_CODE,
    input wire logic [7:0] CMD_ARG,
    input wire logic [7:0] TARGET_SA,
    output logic CMD_READY,
    output logic RX_VALID,
    output logic [28:0] RX_ID,
    output logic [63:0] RX_DATA
);
    import claim_pkg::*;
    logic dn_valid_reg;
    logic [28:0] dn_id_reg;
    logic [63:0] dn_data_reg;

    assign LINK.dn_valid = dn_valid_reg;
    assign LINK.dn_id = dn_id_reg;
    assign LINK.dn_data = dn_data_reg;
    assign LINK.up_ready = 1'b1;

    // ============================================================
    // Command frames
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            dn_valid_reg <= 1'b0;
            dn_id_reg <= 29'h0;
            dn_data_reg <= 64'h0;
            CMD_READY <= 1'b0;
        end else begin
            CMD_READY <= !(dn_valid_reg && !LINK.dn_ready) && !(CMD_VALID && CMD_READY);
            if (CMD_VALID && CMD_READY) begin
                dn_valid_reg <= 1'b1;
                if (CMD_IS_REQUEST) begin
                    dn_id_reg <= make_id(PRIO_CLAIM, PF_REQUEST, TARGET_SA, MY_SA);
                    dn_data_reg <= {40'h0, TARGET_SA, PF_REQUEST, MY_SA};
                end else begin
                    dn_id_reg <= make_id(PRIO_CTRL, PF_PROP_B, PS_CONTROL, MY_SA);
                    if (CMD_CODE == CMD_SET_SA) begin
                        dn_data_reg <= {48'h0, CMD_ARG, CMD_CODE};
                    end else begin
                        dn_data_reg <= {{7{FILL_UNUSED}}, CMD_CODE};
                    end
                end
            end else if (LINK.dn_ready) begin
                dn_valid_reg <= 1'b0;
            end
        end
    end

    // ============================================================
    // Received frames
    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            RX_VALID <= 1'b0;
            RX_ID <= 29'h0;
            RX_DATA <= 64'h0;
        end else begin
            RX_VALID <= LINK.up_valid;
            if (LINK.up_valid) begin
                RX_ID <= LINK.up_id;
                RX_DATA <= LINK.up_data;
            end
        end
    end
endmodule

// *** testbench/claim_link_monitor.sv ***
// Purpose: Checks frame formats and wait-mode silence on the node-master link.
// Assumes: One clock; reset asynchronous and active high.
// Notes: Sees only the link signals, so serial contents are judged by the bench.
module claim_link_monitor #(
    parameter logic [10:0] MAKER_CODE = 11'h000
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic up_valid,
    input wire logic up_ready,
    input wire logic [28:0] up_id,
    input wire logic [63:0] up_data,
    input wire logic dn_valid,
    input wire logic dn_ready,
    input wire logic [28:0] dn_id,
    input wire logic [63:0] dn_data
);
    timeunit 1ns;
    timeprecision 1ps;
    import claim_pkg::*;
    logic claim;
    logic wait_taken;
    assign claim = up_valid && (up_id[23:16] == 8'hEE);
    assign wait_taken = dn_valid && dn_ready && (dn_id[23:16] == 8'hFF)
                        && (dn_data[7:0] == 8'h02);
    default clocking dc @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // ============================================================
    // Address claim frame
    property p_claim_id;
        claim |-> up_id[28:8] == {3'h6, 2'h0, 8'hEE, 8'hFF};
    endproperty
    a_claim_id: assert property (p_claim_id) else $error("claim id wrong");
    property p_claim_maker;
        claim |-> {up_data[31:24], up_data[23:21]} == MAKER_CODE;
    endproperty
    a_claim_maker: assert property (p_claim_maker) else $error("maker field wrong");
    property p_claim_inst;
        claim |-> up_data[39:32] == 8'h00;
    endproperty
    a_claim_inst: assert property (p_claim_inst) else $error("claim byte 4 wrong");
    property p_claim_func;
        claim |-> up_data[47:40] == 8'h88;
    endproperty
    a_claim_func: assert property (p_claim_func) else $error("claim byte 5 wrong");
    property p_claim_vsys;
        claim |-> up_data[55:48] == 8'h00;
    endproperty
    a_claim_vsys: assert property (p_claim_vsys) else $error("claim byte 6 wrong");
    property p_claim_group;
        claim |-> up_data[63:56] == 8'h30;
    endproperty
    a_claim_group: assert property (p_claim_group) else $error("claim byte 7 wrong");
    // ============================================================
    // Other frames
    property p_data_id;
        up_valid && (up_id[15:8] == 8'h53) |-> up_id[28:16] == {3'h4, 2'h0, 8'hFF};
    endproperty
    a_data_id: assert property (p_data_id) else $error("data frame id wrong");
    property p_src_range;
        up_valid |-> (up_id[7:0] == 8'hC0) || (up_id[7:0] >= 8'h80 && up_id[7:0] <= 8'hF7);
    endproperty
    a_src_range: assert property (p_src_range) else $error("source out of range");
    property p_cmd_form;
        dn_valid && (dn_id[23:16] != 8'hEA) |-> dn_id[28:8] == {3'h4, 2'h0, 8'hFF, 8'h54};
    endproperty
    a_cmd_form: assert property (p_cmd_form) else $error("command id wrong");
    property p_req_form;
        dn_valid && (dn_id[23:16] == 8'hEA) |-> dn_id[28:26] == 3'h6
            && dn_data[23:8] == {dn_id[15:8], 8'hEA} && dn_data[7:0] == dn_id[7:0];
    endproperty
    a_req_form: assert property (p_req_form) else $error("request form wrong");
    property p_wait_quiet;
        wait_taken |-> ##5 !up_valid [*8];
    endproperty
    a_wait_quiet: assert property (p_wait_quiet) else $error("frame sent in wait");
endmodule

// *** testbench/can_address_claim_and_master_commands_tb_top.sv ***
// Purpose: Drives the master user side and scores every frame it receives.
// Assumes: Shortened startup and period counts.
// Notes: Data frames are scored apart from the queue of expected replies.
module can_address_claim_and_master_commands_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import claim_pkg::*;
    localparam logic [10:0] MAKER = 11'h5A3; // Value is arbitrary.
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic cmd_valid = 1'b0;
    logic cmd_rq = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] cmd_arg = 8'h00;
    logic [7:0] tgt = 8'h00;
    logic [7:0] sa = 8'hC0;
    logic [7:0] sa_old = 8'hC0;
    logic [7:0] nv_last = 8'h00;
    logic nv_ok = 1'b0;
    logic [20:0] ser = 21'h000000;
    logic [63:0] ser_frame = 64'h0;
    logic [63:0] data_frame = 64'h0;
    logic [15:0] rnd = 16'h3178;
    logic cmd_ready, rx_valid, nv_write, silent;
    logic [28:0] rx_id;
    logic [63:0] rx_data;
    logic [7:0] nv_wdata, src;
    logic [92:0] q[$];
    int fail_count = 0;
    int n_checks = 0;
    int n_data = 0;
    int cycles = 0;
    int nd;
    claim_if link();
    tilt_node #(.MAKER_CODE(MAKER), .STARTUP_CNT(50), .PERIOD_CNT(20)) tilt_node_inst (
        .CORE_CLK(core_clk), .RST(rst), .LINK(link.node), .SERIAL_NUM(ser),
        .SERIAL_FRAME(ser_frame), .DATA_FRAME(data_frame), .NV_SA(nv_last), .NV_SA_VALID(nv_ok),
        .NV_WRITE(nv_write), .NV_WDATA(nv_wdata), .SOURCE_ADDR(src), .SILENT(silent));
    bus_master bus_master_inst (.CORE_CLK(core_clk), .RST(rst), .LINK(link.master),
        .MY_SA(8'h21), .CMD_VALID(cmd_valid), .CMD_IS_REQUEST(cmd_rq), .CMD_CODE(cmd_code),
        .CMD_ARG(cmd_arg), .TARGET_SA(tgt), .CMD_READY(cmd_ready), .RX_VALID(rx_valid),
        .RX_ID(rx_id), .RX_DATA(rx_data));
    claim_link_monitor #(.MAKER_CODE(MAKER)) claim_link_monitor_inst (.CORE_CLK(core_clk),
        .RST(rst), .up_valid(link.up_valid), .up_ready(link.up_ready), .up_id(link.up_id),
        .up_data(link.up_data), .dn_valid(link.dn_valid), .dn_ready(link.dn_ready),
        .dn_id(link.dn_id), .dn_data(link.dn_data));
    always #20 core_clk = ~core_clk;
    // ============================================================
    // Helpers
    function automatic logic [15:0] nx(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic exp_claim(input logic [7:0] s);
        q.push_back({3'h6, 2'h0, 8'hEE, 8'hFF, s, 8'h30, 8'h00, 8'h88, 8'h00, MAKER[10:3],
                     MAKER[2:0], ser[20:16], ser[15:8], ser[7:0]});
    endtask
    task automatic send(input logic rq, input logic [7:0] code, input logic [7:0] arg,
                        input logic [7:0] t);
        int i;
        @(posedge core_clk);
        #1;
        cmd_valid = 1'b1;
        cmd_rq = rq;
        cmd_code = code;
        cmd_arg = arg;
        tgt = t;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (cmd_ready !== 1'b1 && i < 100);
        #1;
        cmd_valid = 1'b0;
        repeat (12) @(posedge core_clk);
    endtask
    // ============================================================
    // Watchers
    always @(posedge core_clk) begin
        if (nv_write === 1'b1) nv_last <= nv_wdata;
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            give_verdict();
        end
    end
    always @(posedge core_clk) begin
        if (rx_valid === 1'b1) begin
            if (rx_id[15:8] === 8'h53) begin
                n_data++;
                chk((rx_id === {21'h10FF53, sa} || rx_id === {21'h10FF53, sa_old})
                    && rx_data === data_frame, "data frame wrong");
            end else if (q.size() == 0) begin
                chk(1'b0, "unexpected frame");
            end else begin
                chk({rx_id, rx_data} === q.pop_front(), "reply frame wrong");
            end
        end
    end
    // ============================================================
    // Scenarios
    initial begin
        rnd = nx(rnd);
        ser = {rnd[4:0], nx(rnd)};
        ser_frame = {rnd, ~rnd, rnd ^ 16'hA5A5, ser[15:0]};
        data_frame = {ser[15:0], ~rnd, rnd, 16'h1234};
        repeat (16) @(posedge core_clk);
        #1;
        rst = 1'b0;
        exp_claim(8'hC0);
        repeat (80) @(posedge core_clk);
        $display("startup claim test done");
        exp_claim(sa);
        send(1'b1, 8'h00, 8'h00, sa);
        send(1'b1, 8'h00, 8'h00, sa ^ 8'h01);
        q.push_back({21'h10FF52, sa, ser_frame});
        send(1'b0, CMD_SERIAL, 8'h00, 8'h00);
        $display("request test done");
        rnd = nx(rnd);
        sa_old = sa;
        sa = 8'h80 + (rnd[7:0] % 8'h78);
        send(1'b0, CMD_SET_SA, sa, 8'h00);
        chk(src === sa && nv_last === sa, "address not stored");
        exp_claim(sa);
        send(1'b1, 8'h00, 8'h00, sa);
        send(1'b1, 8'h00, 8'h00, sa ^ 8'h01);
        send(1'b0, CMD_SET_SA, 8'hF8, 8'h00);
        chk(src === sa, "range not kept");
        $display("address change test done");
        #1;
        rst = 1'b1;
        nv_ok = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        rst = 1'b0;
        exp_claim(sa);
        repeat (80) @(posedge core_clk);
        chk(src === sa, "stored address lost");
        $display("reset reload test done");
        send(1'b0, CMD_WAIT, 8'h00, 8'h00);
        nd = n_data;
        send(1'b1, 8'h00, 8'h00, sa);
        send(1'b0, CMD_SERIAL, 8'h00, 8'h00);
        repeat (40) @(posedge core_clk);
        chk(n_data == nd && silent === 1'b1, "not silent");
        exp_claim(sa);
        send(1'b0, CMD_RESUME, 8'h00, 8'h00);
        send(1'b1, 8'h00, 8'h00, sa);
        repeat (60) @(posedge core_clk);
        chk(n_data > nd && silent === 1'b0, "not resumed");
        chk(q.size() == 0, "reply missing");
        $display("wait and resume test done");
        give_verdict();
    end
endmodule
